//--- hdl/aouc_top.sv
// Purpose : Short I/O bus slave and update control for eight output channels
// Assumes : Bus inputs are synchronous to CLK; jumpers are static levels
// Notes   : Twelve words at the bottom of a 128-byte window
//
// Notes on behaviour
// - Window is 64 sixteen-bit words, placed on any 128-byte boundary.
// - Jumper selects supervisory only, nonprivileged only, or both.
// - Bus control signals ignored unless address and modifier both match.
// - On a match perform the access, then drive acknowledge low.
// - Master ends the cycle; acknowledge released when strobes go away.
// - Selected transfer uses D00-D15, low address lines, write, both strobes.
// - Lines A01-A06 put twelve registers at the window bottom.
// - System reset clears every control/status bit.
// - Control and status share an address; write control, read status.
// - Trigger flags read in trigger byte, ADC flags in ADC status byte.
// - Pointer write selects test multiplexer channel from three bits.
// - Write to ADC word starts conversion of the selected channel.
// - First word is read/write; high byte ident, low byte trigger bits.
// - Each channel double buffered; load copies input to output.
// - Four update modes chosen by control word bits.
// - Automatic mode: writing a channel loads that channel.
// - Internal mode: software trigger bit loads all eight together.
// - External modes: chosen pin edge loads all; control bit picks edge.
// - Control word bit enables response to the external trigger.
// - Status bit sets whenever a load occurs; software then writes next.
// - Software can read the current level of the trigger pin.
// - Board can drive the trigger pin to update other boards.
// - Reset zeroes outputs, clears control word, lights the indicator.
// - Output words are 12-bit right-justified, sign-extended to 16.
module aouc_top
   import aouc_pkg::*;
#(
   parameter logic [7:0] BOARD_IDENT = 8'hA5 // Arbitrary identification value
)(
   // Clock and reset
   input  wire logic                   CLK,
   input  wire logic                   SRST,
   // Selection jumpers
   input  wire logic [BASE_W-1:0]      BASE_SEL,
   input  wire logic [1:0]             AM_SEL,
   // Short I/O bus
   input  wire logic [15:1]            VME_A,
   input  wire logic [5:0]             VME_AM,
   input  wire logic                   VME_AS_N,
   input  wire logic                   VME_DS0_N,
   input  wire logic                   VME_DS1_N,
   input  wire logic                   VME_WRITE_N,
   input  wire logic [15:0]            VME_D_I,
   output logic      [15:0]            VME_D_O,
   output logic                        VME_D_OE,
   output logic                        VME_DTACK_OE,
   // External trigger pin
   input  wire logic                   EXT_TRIG_I,
   output logic                        EXT_TRIG_O,
   output logic                        EXT_TRIG_OE,
   // Converters
   output logic [NUM_CH*DAC_W-1:0]     DAC_OUT,
   // Built-in test multiplexer and ADC
   output logic [2:0]                  MUX_SEL,
   output logic                        ADC_START,
   input  wire logic                   ADC_DONE,
   input  wire logic [DAC_W-1:0]       ADC_DATA,
   // Front panel indicator
   output logic                        LED_ON
);
   typedef struct packed {
      aouc_bus_t        bus;
      logic             dtack;
      logic             d_oe;
      logic [15:0]      rdata;
      logic [7:0]       ctrl;
      logic             drv_lvl;
      logic             drv_en;
      logic             loaded;
      logic [2:0]       mux;
      logic             adc_start;
      logic             adc_busy;
      logic             adc_done;
      logic [DAC_W-1:0] adc_res;
      logic             pin_prev;
   } aouc_st_t;

   aouc_st_t    s_reg;
   aouc_st_t    s_next;
   aouc_chan_if chif ();

   aouc_mode_t  mode;
   logic        am_ok;
   logic        hit;
   logic        strobe;
   logic        sel;
   logic        wr;
   logic [5:0]  idx;
   logic        lo_en;
   logic        hi_en;
   logic        ch_hit;
   logic        sw_trig;
   logic        ext_edge;
   logic        ld_all;
   logic        ld_one;
   logic [7:0]  trig_byte;
   logic [15:0] status_word;
   logic [15:0] rd_mux;
   logic [2:0]  ch_rd;

   // -----------------------------------------------------------------------
   // Selection comparator
   // -----------------------------------------------------------------------
   always_comb begin
      case (AM_SEL)
         AMSEL_SUPER: am_ok = (VME_AM == AM_SUPER);
         AMSEL_USER:  am_ok = (VME_AM == AM_USER);
         default:     am_ok = (VME_AM == AM_SUPER) || (VME_AM == AM_USER);
      endcase
   end

   // Window base on A15..A07, so any 128-byte boundary works
   assign hit    = !VME_AS_N && (VME_A[15:7] == BASE_SEL) && am_ok;
   assign strobe = !VME_DS0_N || !VME_DS1_N;
   // Nothing on the bus is looked at unless hit is true
   assign sel    = hit && strobe && (s_reg.bus == BUS_IDLE);
   assign wr     = !VME_WRITE_N;
   assign idx    = VME_A[6:1];
   assign lo_en  = !VME_DS0_N;
   assign hi_en  = !VME_DS1_N;
   assign ch_hit = (idx >= IDX_CH0) && (idx <= IDX_LAST);
   assign mode   = aouc_mode_t'(s_reg.ctrl[CW_MODE_LO +: 2]);

   // -----------------------------------------------------------------------
   // Load sources
   // -----------------------------------------------------------------------
   // Software trigger is a write-one pulse, never stored
   assign sw_trig = sel && wr && lo_en && (idx == IDX_IDENT)
                    && VME_D_I[TB_SWTRIG];
   // Pin edge, polarity chosen by the control word; gated by enable
   assign ext_edge = s_reg.ctrl[CW_EXTEN]
                     && (s_reg.ctrl[CW_RISE] ? (EXT_TRIG_I && !s_reg.pin_prev)
                                             : (!EXT_TRIG_I && s_reg.pin_prev));

   always_comb begin
      ld_all = 1'b0;
      ld_one = 1'b0;
      case (mode)
         MODE_AUTO:  ld_one = sel && wr && ch_hit;
         MODE_SOFT:  ld_all = sw_trig;
         MODE_EXT:   ld_all = ext_edge;
         MODE_EXTSW: ld_all = ext_edge || sw_trig;
         default:    ld_all = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------------
   // Channel bank connection
   // -----------------------------------------------------------------------
   assign chif.wr_en   = sel && wr && ch_hit;
   assign chif.wr_ch   = 3'(idx - IDX_CH0);
   assign chif.wr_data = VME_D_I[DAC_W-1:0];
   assign chif.ld_one  = ld_one;
   assign chif.ld_all  = ld_all;

   aouc_bank u_bank (
      .CLK  (CLK),
      .SRST (SRST),
      .ch   (chif.bank)
   );

   // -----------------------------------------------------------------------
   // Read data selection
   // -----------------------------------------------------------------------
   assign trig_byte = {3'b000, s_reg.drv_en, s_reg.drv_lvl,
                       EXT_TRIG_I, s_reg.loaded, 1'b0};
   assign status_word = {6'b000000, s_reg.adc_done, s_reg.adc_busy,
                         s_reg.ctrl};
   assign ch_rd = 3'(idx - IDX_CH0);

   always_comb begin
      rd_mux = ZERO_WORD;
      if (idx == IDX_IDENT) begin
         rd_mux = {BOARD_IDENT, trig_byte};
      end else if (idx == IDX_CSR) begin
         rd_mux = status_word;
      end else if (idx == IDX_PTR) begin
         rd_mux = {13'h0000, s_reg.mux};
      end else if (idx == IDX_ADC) begin
         rd_mux = {{4{s_reg.adc_res[DAC_W-1]}}, s_reg.adc_res};
      end else if (ch_hit) begin
         // Readback sign-extended from the converter output register
         rd_mux = {{4{chif.out_val[ch_rd][DAC_W-1]}},
                   chif.out_val[ch_rd]};
      end
   end

   // -----------------------------------------------------------------------
   // Next-state logic: bus handshake, registers, ADC status
   // -----------------------------------------------------------------------
   always_comb begin
      s_next           = s_reg;
      s_next.adc_start = 1'b0;
      s_next.pin_prev  = EXT_TRIG_I;
      case (s_reg.bus)
         BUS_IDLE: begin
            if (sel) begin
               // Access is done in this cycle, acknowledge follows
               s_next.bus   = BUS_ACK;
               s_next.dtack = 1'b1;
               s_next.d_oe  = !wr;
               s_next.rdata = wr ? ZERO_WORD : rd_mux;
            end
         end
         BUS_ACK: begin
            // Released only once the master drops both strobes
            if (!strobe) begin
               s_next.bus   = BUS_IDLE;
               s_next.dtack = 1'b0;
               s_next.d_oe  = 1'b0;
            end
         end
         default: begin
            s_next.bus   = BUS_IDLE;
            s_next.dtack = 1'b0;
            s_next.d_oe  = 1'b0;
         end
      endcase

      // Register writes, lane by lane where the lane matters
      if (sel && wr) begin
         if ((idx == IDX_IDENT) && lo_en) begin
            s_next.drv_lvl = VME_D_I[TB_DRVLVL];
            s_next.drv_en  = VME_D_I[TB_DRVEN];
            if (VME_D_I[TB_LOADED]) begin
               s_next.loaded = 1'b0;
            end
         end
         if ((idx == IDX_CSR) && lo_en) begin
            s_next.ctrl = VME_D_I[7:0];
         end
         if ((idx == IDX_PTR) && lo_en) begin
            s_next.mux = VME_D_I[2:0];
         end
         if (idx == IDX_ADC) begin
            s_next.adc_start = 1'b1;
            s_next.adc_busy  = 1'b1;
            s_next.adc_done  = 1'b0;
         end
      end

      // Set wins over the software clear in the same cycle
      if (ld_all || ld_one) begin
         s_next.loaded = 1'b1;
      end
      if (ADC_DONE && s_reg.adc_busy) begin
         s_next.adc_busy = 1'b0;
         s_next.adc_done = 1'b1;
         s_next.adc_res  = ADC_DATA;
      end
   end

   // Synchronous reset clears the whole state, control word included
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_reg      <= '0;
         s_reg.ctrl <= CTRL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs, all from flip-flops
   // -----------------------------------------------------------------------
   assign VME_D_O      = s_reg.rdata;
   assign VME_D_OE     = s_reg.d_oe;
   assign VME_DTACK_OE = s_reg.dtack;
   assign EXT_TRIG_O   = s_reg.drv_lvl;
   assign EXT_TRIG_OE  = s_reg.drv_en;
   assign DAC_OUT      = chif.out_val;
   assign MUX_SEL      = s_reg.mux;
   assign ADC_START    = s_reg.adc_start;
   // Indicator lit until software sets the off bit
   assign LED_ON       = !s_reg.ctrl[CW_LEDOFF];

   // -----------------------------------------------------------------------
   // Assertions and covers
   // -----------------------------------------------------------------------
   AST_NO_ACK_WITHOUT_HIT: assert property (@(posedge CLK) disable iff (SRST)
      $rose(VME_DTACK_OE) |-> $past(hit && strobe))
      else $error("Acknowledge without a selection match");
   AST_ACK_AFTER_SEL: assert property (@(posedge CLK) disable iff (SRST)
      sel |=> VME_DTACK_OE)
      else $error("Selected access not acknowledged");
   AST_ACK_RELEASE: assert property (@(posedge CLK) disable iff (SRST)
      VME_DTACK_OE && !strobe |=> !VME_DTACK_OE)
      else $error("Acknowledge held after strobes released");
   AST_ACK_HOLD: assert property (@(posedge CLK) disable iff (SRST)
      VME_DTACK_OE && strobe |=> VME_DTACK_OE)
      else $error("Acknowledge dropped while strobes active");
   AST_RESET_CLEAR: assert property (@(posedge CLK)
      SRST |=> s_reg.ctrl == CTRL_RESET && LED_ON && DAC_OUT == '0)
      else $error("Reset did not clear state");
   AST_CSR_WRITE: assert property (@(posedge CLK) disable iff (SRST)
      sel && wr && lo_en && idx == IDX_CSR |=> s_reg.ctrl == $past(VME_D_I[7:0]))
      else $error("Control word not written");
   AST_MUX_WRITE: assert property (@(posedge CLK) disable iff (SRST)
      sel && wr && lo_en && idx == IDX_PTR |=> MUX_SEL == $past(VME_D_I[2:0]))
      else $error("Multiplexer channel not taken");
   AST_ADC_START: assert property (@(posedge CLK) disable iff (SRST)
      sel && wr && idx == IDX_ADC |=> ADC_START ##1 !ADC_START)
      else $error("Conversion start not a single pulse");
   AST_LOAD_FLAG: assert property (@(posedge CLK) disable iff (SRST)
      ld_all || ld_one |=> s_reg.loaded)
      else $error("Load status not set");
   AST_AUTO_LOAD: assert property (@(posedge CLK) disable iff (SRST)
      mode == MODE_AUTO && sel && wr && ch_hit
      |=> chif.out_val[$past(ch_rd)] == $past(VME_D_I[DAC_W-1:0]))
      else $error("Automatic mode did not load channel");
   AST_EXT_GATED: assert property (@(posedge CLK) disable iff (SRST)
      !s_reg.ctrl[CW_EXTEN] && mode == MODE_EXT |-> !ld_all)
      else $error("Disabled external trigger caused a load");
   AST_IDENT_READ: assert property (@(posedge CLK) disable iff (SRST)
      sel && !wr && idx == IDX_IDENT |=> VME_D_O[15:8] == BOARD_IDENT)
      else $error("Ident byte wrong");

   COV_SOFT_LOAD: cover property (@(posedge CLK) disable iff (SRST)
      mode == MODE_SOFT && sw_trig);
   COV_EXT_LOAD:  cover property (@(posedge CLK) disable iff (SRST)
      mode == MODE_EXT && ext_edge);
   COV_READ_ACK:  cover property (@(posedge CLK) disable iff (SRST)
      sel && !wr ##1 VME_D_OE ##[1:8] !VME_DTACK_OE);
endmodule : aouc_top

//--- hdl/aouc_pkg.sv
// Purpose : Shared constants and types for the analog output update control
// Assumes : 16-bit word registers indexed by address lines A01..A06
// Notes   : Word index equals the byte offset divided by two
package aouc_pkg;
   // ---------------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------------
   localparam int          NUM_CH      = 8;
   localparam int          DAC_W       = 12;
   localparam int          IDX_W       = 6;
   localparam int          BASE_W      = 9;
   // ---------------------------------------------------------------------
   // Register word indexes inside the 128-byte window
   // ---------------------------------------------------------------------
   localparam logic [5:0]  IDX_IDENT   = 6'h00;
   localparam logic [5:0]  IDX_CSR     = 6'h01;
   localparam logic [5:0]  IDX_PTR     = 6'h02;
   localparam logic [5:0]  IDX_ADC     = 6'h03;
   localparam logic [5:0]  IDX_CH0     = 6'h04;
   localparam logic [5:0]  IDX_LAST    = 6'h0B;
   // ---------------------------------------------------------------------
   // Address modifiers and selection modes
   // ---------------------------------------------------------------------
   localparam logic [5:0]  AM_USER     = 6'h29;
   localparam logic [5:0]  AM_SUPER    = 6'h2D;
   localparam logic [1:0]  AMSEL_BOTH  = 2'h0;
   localparam logic [1:0]  AMSEL_SUPER = 2'h1;
   localparam logic [1:0]  AMSEL_USER  = 2'h2;
   // ---------------------------------------------------------------------
   // Trigger byte fields (low byte of the ident word)
   // ---------------------------------------------------------------------
   localparam int          TB_SWTRIG   = 0;
   localparam int          TB_LOADED   = 1;
   localparam int          TB_PINLVL   = 2;
   localparam int          TB_DRVLVL   = 3;
   localparam int          TB_DRVEN    = 4;
   // ---------------------------------------------------------------------
   // Control word fields and status fields
   // ---------------------------------------------------------------------
   localparam int          CW_MODE_LO  = 0;
   localparam int          CW_RISE     = 2;
   localparam int          CW_EXTEN    = 3;
   localparam int          CW_LEDOFF   = 4;
   localparam int          SW_ADCBUSY  = 8;
   localparam int          SW_ADCDONE  = 9;
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [15:0] ZERO_WORD   = 16'h0000;

   typedef enum logic [1:0] {
      MODE_AUTO  = 2'b00,
      MODE_SOFT  = 2'b01,
      MODE_EXT   = 2'b10,
      MODE_EXTSW = 2'b11
   } aouc_mode_t;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } aouc_bus_t;
endpackage : aouc_pkg

//--- hdl/aouc_chan_if.sv
// Purpose : Carrier between the bus/control logic and the channel bank
// Assumes : Single clock domain
// Notes   : Write strobe and load strobes are one-cycle pulses
interface aouc_chan_if;
   import aouc_pkg::*;
   logic                         wr_en;
   logic [2:0]                   wr_ch;
   logic [DAC_W-1:0]             wr_data;
   logic                         ld_one;
   logic                         ld_all;
   logic [NUM_CH-1:0][DAC_W-1:0] out_val;

   modport ctrl (output wr_en, output wr_ch, output wr_data,
                 output ld_one, output ld_all, input out_val);
   modport bank (input wr_en, input wr_ch, input wr_data,
                 input ld_one, input ld_all, output out_val);
endinterface : aouc_chan_if

//--- hdl/aouc_bank.sv
// Purpose : Double-buffered converter channels
// Assumes : Writes and loads arrive as single-cycle strobes
// Notes   : A write and a load in the same cycle pass the new value through
module aouc_bank
   import aouc_pkg::*;
(
   // Clock and reset
   input  wire logic CLK,
   input  wire logic SRST,
   // Control side
   aouc_chan_if.bank ch
);
   typedef struct packed {
      logic [NUM_CH-1:0][DAC_W-1:0] in_v;
      logic [NUM_CH-1:0][DAC_W-1:0] out_v;
   } aouc_bank_st_t;

   aouc_bank_st_t s_reg;
   aouc_bank_st_t s_next;

   // -----------------------------------------------------------------------
   // Per-channel input and output registers
   // -----------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      for (int i = 0; i < NUM_CH; i++) begin
         // Input register only changes on a write to its own channel
         if (ch.wr_en && (ch.wr_ch == 3'(i))) begin
            s_next.in_v[i] = ch.wr_data;
         end
         // Loads copy the (possibly just written) input value
         if (ch.ld_all || (ch.ld_one && (ch.wr_ch == 3'(i)))) begin
            s_next.out_v[i] = s_next.in_v[i];
         end
      end
   end

   // Reset drives every converter to zero
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ch.out_val = s_reg.out_v;

   AST_HOLD_NO_LOAD: assert property (@(posedge CLK) disable iff (SRST)
      !ch.ld_all && !ch.ld_one |=> s_reg.out_v == $past(s_reg.out_v))
      else $error("Output register changed without a load");
endmodule : aouc_bank

//--- dv/aouc_vme_master.sv
// Purpose : Short I/O bus master model issuing word cycles
// Assumes : Bus lines change on the falling edge of clk
// Notes   : Released data and address lines show inverted values
module aouc_vme_master (
   input  wire logic        clk,
   input  wire logic        dtack_oe,
   input  wire logic [15:0] d_o,
   output logic      [15:1] a,
   output logic      [5:0]  am,
   output logic             as_n,
   output logic             ds0_n,
   output logic             ds1_n,
   output logic             write_n,
   output logic      [15:0] d_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Idle bus
   // ------------------------------------------------------------
   initial begin
      {as_n, ds0_n, ds1_n, write_n} = 4'hF;
      a = 15'h0000;
      am = 6'h00;
      d_i = 16'h0000;
   end
   // One word cycle; ack stays 0 if nobody answers in 8 cycles
   task automatic xfer(input logic [15:1] ad, input logic [5:0] m,
                       input logic wr, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ack);
      int n;
      @(negedge clk);
      a = ad;
      am = m;
      write_n = ~wr;
      d_i = wr ? wd : ~d_i;
      as_n = 1'b0;
      {ds0_n, ds1_n} = 2'b00;
      ack = 1'b0;
      rd = 16'h0000;
      for (n = 0; n < 8 && !ack; n++) begin
         @(posedge clk);
         if (dtack_oe === 1'b1) begin
            ack = 1'b1;
            rd = d_o;
         end
      end
      // Master ends the cycle, then waits for the answer to drop
      @(negedge clk);
      {as_n, ds0_n, ds1_n, write_n} = 4'hF;
      d_i = ~d_i;
      a = ~a;
      for (n = 0; n < 4 && dtack_oe === 1'b1; n++) @(posedge clk);
   endtask : xfer
endmodule : aouc_vme_master

//--- dv/test_analog_output_update_control.sv
// Purpose : Self-checking bench for the update control block
// Assumes : Random values from a fixed seed, inputs on falling edge
// Notes   : Expected channel outputs kept in a shadow vector
module test_analog_output_update_control
   import aouc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] IDV = 8'h5C; // Arbitrary value
   logic clk, srst, ext_i, adc_done, ack;
   logic [8:0] base;
   logic [1:0] amsel;
   logic [11:0] adc_data, v;
   logic [15:0] r;
   logic [95:0] exp_dac, ins;
   wire [15:1] a;
   wire [5:0] am;
   wire as_n, ds0_n, ds1_n, wr_n, d_oe, dt_oe, t_o, t_oe, adc_st, led;
   wire [15:0] d_i, d_o;
   wire [95:0] dac;
   wire [2:0] mux;
   int fails, n_tests, seed, starts, cyc;
   aouc_top #(.BOARD_IDENT(IDV)) uut (.CLK(clk), .SRST(srst),
      .BASE_SEL(base), .AM_SEL(amsel), .VME_A(a), .VME_AM(am),
      .VME_AS_N(as_n), .VME_DS0_N(ds0_n), .VME_DS1_N(ds1_n),
      .VME_WRITE_N(wr_n), .VME_D_I(d_i), .VME_D_O(d_o),
      .VME_D_OE(d_oe), .VME_DTACK_OE(dt_oe), .EXT_TRIG_I(ext_i),
      .EXT_TRIG_O(t_o), .EXT_TRIG_OE(t_oe), .DAC_OUT(dac),
      .MUX_SEL(mux), .ADC_START(adc_st), .ADC_DONE(adc_done),
      .ADC_DATA(adc_data), .LED_ON(led));
   aouc_vme_master m (.clk(clk), .dtack_oe(dt_oe), .d_o(d_o), .a(a),
      .am(am), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
      .write_n(wr_n), .d_i(d_i));
   // ------------------------------------------------------------
   // Clock, start counter and hang guard
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      starts <= starts + (adc_st === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   function automatic logic [15:0] sx(logic [11:0] x);
      return {{4{x[11]}}, x};
   endfunction : sx
   task automatic chk(string nm, logic [95:0] e, logic [95:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(logic [5:0] i, logic [15:0] d);
      m.xfer({base, i}, AM_SUPER, 1'b1, d, r, ack);
   endtask : wr
   task automatic rd(logic [5:0] i);
      m.xfer({base, i}, AM_SUPER, 1'b0, 16'h0000, r, ack);
   endtask : rd
   // New random input values on all channels, outputs follow only in automatic mode
   task automatic fill();
      for (int c = 0; c < 8; c++) begin
         v = $random(seed);
         ins[c*12+:12] = v;
         wr(IDX_CH0 + c, sx(v));
      end
   endtask : fill
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {fails, n_tests, starts, cyc} = '0;
      seed = 7606;
      {srst, ext_i, adc_done, amsel, adc_data} = {1'b1, 16'h0000};
      base = $random(seed);
      repeat (20) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      chk("dac", 96'h0, dac);
      chk("led", 1, led);
      rd(IDX_IDENT);
      chk("ident", IDV, r[15:8]);
      rd(IDX_CSR);
      chk("csr", 0, r);
      $display("reset test done");
      for (int s = 0; s < 4; s++)
         for (int k = 0; k < 2; k++) begin
            @(negedge clk) amsel = s;
            m.xfer({base, IDX_IDENT}, k ? AM_SUPER : AM_USER, 1'b0,
                   16'h0000, r, ack);
            chk("am", s == 0 || s == 3 || s == (k ? 1 : 2), ack);
         end
      // Back to both modifiers so the supervisory cycles below are taken
      @(negedge clk) amsel = 2'h0;
      m.xfer({~base, IDX_IDENT}, AM_SUPER, 1'b0, 16'h0000, r, ack);
      chk("base miss", 0, ack);
      m.xfer({base, IDX_IDENT}, 6'h39, 1'b1, 16'h0001, r, ack);
      chk("am miss", 0, ack);
      @(negedge clk) base = $random(seed);
      wr(6'd12 + ($random(seed) & 6'h1F), 16'hFFFF);
      rd(6'd63);
      chk("unmapped", 17'h1_0000, {ack, r});
      $display("select test done");
      ins = '0;
      fill();
      exp_dac = ins;
      chk("auto", exp_dac, dac);
      rd(IDX_CH0 + 7);
      chk("readback", sx(ins[95:84]), r);
      rd(IDX_IDENT);
      chk("loaded", 1, r[TB_LOADED]);
      wr(IDX_IDENT, 16'h0002);
      rd(IDX_IDENT);
      chk("cleared", 0, r[TB_LOADED]);
      for (int md = 1; md < 4; md += 2) begin
         wr(IDX_CSR, md);
         fill();
         chk("held", exp_dac, dac);
         wr(IDX_IDENT, 16'h0001);
         exp_dac = ins;
         chk("soft", exp_dac, dac);
      end
      wr(IDX_CSR, 16'h0006);
      fill();
      @(negedge clk) ext_i = 1'b1;
      repeat (3) @(posedge clk);
      chk("ext off", exp_dac, dac);
      rd(IDX_IDENT);
      chk("pin", 1, r[TB_PINLVL]);
      wr(IDX_CSR, 16'h000A);
      @(negedge clk) ext_i = 1'b0;
      repeat (3) @(posedge clk);
      exp_dac = ins;
      chk("ext fall", exp_dac, dac);
      wr(IDX_CSR, 16'h000E);
      fill();
      @(negedge clk) ext_i = 1'b1;
      repeat (3) @(posedge clk);
      exp_dac = ins;
      chk("ext rise", exp_dac, dac);
      wr(IDX_IDENT, 16'h0018);
      chk("drive", 2'b11, {t_o, t_oe});
      $display("update test done");
      v = $random(seed);
      wr(IDX_PTR, v);
      chk("mux", v[2:0], mux);
      wr(IDX_ADC, 16'h0000);
      chk("start", 1, starts);
      rd(IDX_CSR);
      chk("busy", 2'b01, r[9:8]);
      @(negedge clk) {adc_done, adc_data} = {1'b1, v};
      @(negedge clk) adc_done = 1'b0;
      rd(IDX_ADC);
      chk("adc", sx(v), r);
      wr(IDX_CSR, 16'h0010);
      chk("led off", 0, led);
      rd(IDX_CSR);
      chk("status", 16'h0210, r);
      @(negedge clk) srst = 1'b1;
      @(negedge clk) srst = 1'b0;
      chk("rereset", {1'b1, 96'h0}, {led, dac});
      $display("adc test done");
      summarize();
   end
endmodule : test_analog_output_update_control
